// [src/motor_pkg.sv]
// Summary of operation
// - Drive code is 12-bit magnitude plus sign, limited to -4095..+4095.
// - Reference equals zero offset plus span times drive code over 4095.
// - Default bipolar reference; positive code forward, negative code reverse.
// - Contactor-reverse output is off for forward and on for reverse.
// - With contactor reversing, the reference and drive sign take the code magnitude, never negative.
// - Jog ramp code bit 0 enables acceleration, bit 1 enables deceleration.
// - Jog acceleration ramps toward jog set-point, deceleration ramps toward 0.
// - Open-loop closed: bit 0 cuts encoder pulses, bit 1 cuts index pulses.
// - Mode select 0 chooses follower, 1 chooses master.
// - Assigned master/follower switch input overrides the keypad mode select.
// - Closed jog switch input forces jog mode over master or follower.
// - Loop computation and phase error update run 1024 times per second.
// - External phase error split into 1024 times release-time parts, one per update.
// - Release time accepted from 0.01 to 100.0 seconds.
// - Phase error sources: index measurement in index-follower, scroll in master/ratio.
// - Four set-points per master, ratio, index mode, one for jog; switch or keypad.
// - In follower operation kind 0 selects ratio, 1 selects index follower.
// - Keypad set-point selectors ignored when set-point switch inputs are assigned.
package motor_pkg;
  localparam int unsigned CLK_HZ_DEF     = 32'h0773_5940;
  localparam logic [31:0] LOOP_HZ        = 32'h0000_0400;
  localparam logic [31:0] CS_PER_S       = 32'h0000_0064;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_SEL        = 8'h04;
  localparam logic [7:0]  OFS_RELEASE    = 8'h08;
  localparam logic [7:0]  OFS_CAL        = 8'h0c;
  localparam logic [7:0]  OFS_RAMP       = 8'h10;
  localparam logic [7:0]  OFS_CMD        = 8'h14;
  localparam logic [7:0]  OFS_SCROLL     = 8'h18;
  localparam logic [7:0]  OFS_STATUS     = 8'h1c;
  localparam logic [7:0]  OFS_PHASE      = 8'h20;
  localparam logic [7:0]  OFS_REF        = 8'h24;
  localparam logic [7:0]  OFS_SP_BASE    = 8'h40;
  localparam logic [7:0]  OFS_SP_LAST    = 8'h70;
  localparam logic [3:0]  JOG_SP_IDX     = 4'hc;
  localparam logic [12:0] DRIVE_MAX      = 13'h0fff;
  localparam logic [31:0] DRIVE_DIV      = 32'h0000_0fff;
  localparam logic [13:0] RELEASE_CS_MIN = 14'h0001;
  localparam logic [13:0] RELEASE_CS_MAX = 14'h2710;
  localparam logic [13:0] RELEASE_CS_RST = 14'h0064;
  localparam logic [10:0] CTRL_RST       = 11'h001;
  localparam logic [5:0]  SEL_RST        = 6'h00;
  localparam logic [15:0] OFFSET_RST     = 16'h0000;
  localparam logic [15:0] SPAN_RST       = 16'h2710;
  localparam logic [11:0] RAMP_RST       = 12'h001;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    MODE_MASTER = 2'b00,
    MODE_RATIO  = 2'b01,
    MODE_INDEX  = 2'b10,
    MODE_JOG    = 2'b11
  } mode_t;

  typedef struct packed {
    logic       open_loop_assigned;
    logic       jog_assigned;
    logic       sp_sw_assigned;
    logic       mf_sw_assigned;
    logic       contactor_assigned;
    logic [1:0] open_loop_effect_config;
    logic [1:0] jog_ramp_config;
    logic       follower_kind_select;
    logic       master_follower_select;
  } ctrl_t;

  typedef struct packed {
    logic       jog;
    logic       open_loop;
    logic       mf;
    logic [1:0] sp;
    logic       fb_enc;
    logic       fb_idx;
  } sw_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage

// [src/phase_release.sv]
`timescale 1ns/1ns
module phase_release (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_tick,
  input  wire logic        i_load,
  input  wire logic [31:0] i_err,
  input  wire logic [16:0] i_parts,
  output logic [31:0]      o_part,
  output logic             o_part_valid,
  output logic             o_busy
);
  typedef struct packed {
    logic [31:0] left;
    logic [16:0] ticks;
    logic [31:0] part;
    logic        valid;
  } rel_t;

  rel_t        r_reg;
  rel_t        r_next;
  logic [31:0] base_left;
  logic [16:0] base_ticks;
  logic [31:0] quot;

  always_comb
  begin
    r_next     = r_reg;
    r_next.valid = 1'b0;
    // A new error joins what is still undelivered and restarts the spread
    base_left  = r_reg.left + (i_load ? i_err : 32'h0000_0000);
    base_ticks = i_load ? i_parts : r_reg.ticks;
    quot       = 32'h0000_0000;
    r_next.left  = base_left;
    r_next.ticks = base_ticks;
    if (i_tick && base_ticks != 17'h0_0000)
    begin
      // Last tick divides by one, so the remainder is released exactly
      quot         = 32'($signed(base_left) / $signed({15'h0000, base_ticks}));
      r_next.part  = quot;
      r_next.left  = base_left - quot;
      r_next.ticks = base_ticks - 17'h0_0001;
      r_next.valid = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign o_part       = r_reg.part;
  assign o_part_valid = r_reg.valid;
  assign o_busy       = (r_reg.ticks != 17'h0_0000);
endmodule // phase_release

// [src/motor_output_mode_control.sv]
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module motor_output_mode_control #(
  parameter int unsigned CLK_HZ = motor_pkg::CLK_HZ_DEF
) (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire motor_pkg::axi_req_t i_axi,
  output motor_pkg::axi_rsp_t     o_axi,
  input  wire motor_pkg::sw_t     i_sw,
  input  wire logic               i_idx_meas_valid,
  input  wire logic [31:0]        i_idx_meas_err,
  output logic [11:0]             o_drive_mag,
  output logic                    o_drive_neg,
  output logic                    o_contactor_rev,
  output logic [31:0]             o_ref_value,
  output logic                    o_fb_enc_pulse,
  output logic                    o_fb_idx_pulse,
  output logic                    o_loop_tick,
  output motor_pkg::mode_t        o_mode,
  output logic [15:0]             o_setpoint,
  output logic [31:0]             o_phase_err
);
  import motor_pkg::*;

  typedef struct packed {
    sw_t              sync1;
    sw_t              sync2;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    ctrl_t            ctrl;
    logic [5:0]       sel;
    logic [13:0]      rel_cs;
    logic [15:0]      offset;
    logic [15:0]      span;
    logic [11:0]      ramp;
    logic [15:0]      cmd;
    logic [12:0][15:0] sp;
    logic [31:0]      tick_acc;
    logic             tick;
    logic [12:0]      code;
    logic             dec;
    mode_t            mode;
    logic [3:0]       sp_idx;
    logic [15:0]      sp_val;
    logic [11:0]      drive_mag;
    logic             drive_neg;
    logic             contactor_rev;
    logic             enc_out;
    logic             idx_out;
    logic [31:0]      ref_v;
    logic [31:0]      phase_err;
    logic             inj;
    logic [31:0]      inj_err;
  } st_t;

  st_t         r_reg;
  st_t         r_next;
  sw_t         sw;
  logic        mf;
  logic        open_loop_on;
  logic [1:0]  spsel;
  logic [12:0] tgt;
  logic [12:0] code_new;
  logic [12:0] out_code;
  logic        away;
  logic        ramp_on;
  logic [31:0] wv;
  logic [31:0] prod;
  logic [31:0] parts_full;
  logic [16:0] parts;
  logic [31:0] rel_part;
  logic        rel_valid;
  logic        rel_busy;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = nv[8*b +: 8];
    return res;
  endfunction

  function automatic logic sp_hit(input logic [7:0] a);
    return (a >= OFS_SP_BASE) && (a <= OFS_SP_LAST) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [3:0] sp_pos(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_SP_BASE;
    return d[5:2];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return sp_hit(a) || (a[1:0] == 2'b00 && a <= OFS_REF);
  endfunction

  function automatic logic [12:0] clamp13(input logic [15:0] v);
    if ($signed(v) > $signed({3'b000, DRIVE_MAX}))
      return DRIVE_MAX;
    else if ($signed(v) < -$signed({3'b000, DRIVE_MAX}))
      return -DRIVE_MAX;
    else
      return v[12:0];
  endfunction

  function automatic logic [12:0] abs13(input logic [12:0] v);
    return v[12] ? -v : v;
  endfunction

  function automatic logic [12:0] step_to(input logic [12:0] cur, input logic [12:0] t,
                                          input logic [11:0] st);
    logic [13:0] diff;
    diff = 14'($signed(t) - $signed(cur));
    if ($signed(diff) > $signed({2'b00, st}))
      return cur + {1'b0, st};
    else if ($signed(diff) < -$signed({2'b00, st}))
      return cur - {1'b0, st};
    else
      return t;
  endfunction

  // Parts per spread, rounded to the nearest whole loop update
  assign parts_full = ({18'h0_0000, r_reg.rel_cs} * LOOP_HZ + (CS_PER_S >> 1)) / CS_PER_S;
  assign parts      = parts_full[16:0];

  phase_release u_release (
    .i_clk        (i_clk),
    .i_nrst       (i_nrst),
    .i_tick       (r_reg.tick),
    .i_load       (r_reg.inj),
    .i_err        (r_reg.inj_err),
    .i_parts      (parts),
    .o_part       (rel_part),
    .o_part_valid (rel_valid),
    .o_busy       (rel_busy)
  );

  always_comb
  begin
    r_next       = r_reg;
    r_next.tick  = 1'b0;
    r_next.inj   = 1'b0;
    r_next.sync1 = i_sw;
    r_next.sync2 = r_reg.sync1;
    sw           = r_reg.sync2;
    wv           = 32'h0000_0000;

    // Operating mode
    mf = r_reg.ctrl.mf_sw_assigned ? sw.mf : r_reg.ctrl.master_follower_select;
    if (r_reg.ctrl.jog_assigned && sw.jog)
      r_next.mode = MODE_JOG;
    else if (mf)
      r_next.mode = MODE_MASTER;
    else if (r_reg.ctrl.follower_kind_select)
      r_next.mode = MODE_INDEX;
    else
      r_next.mode = MODE_RATIO;

    // Active set-point
    case (r_reg.mode)
      MODE_RATIO: spsel = r_reg.sel[3:2];
      MODE_INDEX: spsel = r_reg.sel[5:4];
      default:    spsel = r_reg.sel[1:0];
    endcase
    if (r_reg.ctrl.sp_sw_assigned)
      spsel = sw.sp;
    r_next.sp_idx = (r_reg.mode == MODE_JOG) ? JOG_SP_IDX : {r_reg.mode, spsel};
    r_next.sp_val = r_reg.sp[r_reg.sp_idx];

    // Feedback pulse gating while open loop
    open_loop_on   = r_reg.ctrl.open_loop_assigned && sw.open_loop;
    r_next.enc_out = sw.fb_enc && !(open_loop_on && r_reg.ctrl.open_loop_effect_config[0]);
    r_next.idx_out = sw.fb_idx && !(open_loop_on && r_reg.ctrl.open_loop_effect_config[1]);

    // Loop update rate from a fractional accumulator
    if (r_reg.tick_acc + LOOP_HZ >= CLK_HZ)
    begin
      r_next.tick_acc = r_reg.tick_acc + LOOP_HZ - CLK_HZ;
      r_next.tick     = 1'b1;
    end
    else
      r_next.tick_acc = r_reg.tick_acc + LOOP_HZ;

    // Drive code: jog ramps, otherwise loop command
    if (r_reg.mode == MODE_JOG)
      tgt = clamp13(r_reg.sp[JOG_SP_IDX]);
    else if (r_reg.dec)
      tgt = 13'h0000;
    else
      tgt = clamp13(r_reg.cmd);
    away    = (abs13(tgt) > abs13(r_reg.code)) &&
              (tgt[12] == r_reg.code[12] || r_reg.code == 13'h0000);
    ramp_on = (r_reg.mode == MODE_JOG || r_reg.dec) &&
              (away ? r_reg.ctrl.jog_ramp_config[0] : r_reg.ctrl.jog_ramp_config[1]);
    code_new = ramp_on ? step_to(r_reg.code, tgt, r_reg.ramp) : tgt;
    if (r_reg.tick)
    begin
      r_next.code = code_new;
      r_next.dec  = (r_reg.mode == MODE_JOG) ? r_reg.ctrl.jog_ramp_config[1] :
                    (r_reg.dec && code_new != 13'h0000);
    end

    // Output stage: bipolar by default, unipolar plus contactor when assigned
    out_code = r_reg.ctrl.contactor_assigned ? abs13(r_reg.code) : r_reg.code;
    r_next.drive_mag     = 12'(abs13(r_reg.code));
    r_next.drive_neg     = out_code[12];
    r_next.contactor_rev = r_reg.ctrl.contactor_assigned && r_reg.code[12];
    prod = 32'($signed({16'h0000, r_reg.span}) * $signed({{19{out_code[12]}}, out_code}));
    if (r_reg.tick)
      r_next.ref_v = 32'($signed({{16{r_reg.offset[15]}}, r_reg.offset}) +
                         $signed(prod) / $signed(DRIVE_DIV));

    // Phase error sources
    if (i_idx_meas_valid && r_reg.mode == MODE_INDEX)
    begin
      r_next.inj     = 1'b1;
      r_next.inj_err = i_idx_meas_err;
    end

    // Register writes
    if (i_axi.awvalid && r_reg.awready)
    begin
      r_next.aw_have = 1'b1;
      r_next.awaddr  = i_axi.awaddr;
      r_next.awready = 1'b0;
    end
    if (i_axi.wvalid && r_reg.wready)
    begin
      r_next.w_have = 1'b1;
      r_next.wdata  = i_axi.wdata;
      r_next.wstrb  = i_axi.wstrb;
      r_next.wready = 1'b0;
    end
    if (rel_valid)
      r_next.phase_err = r_reg.phase_err + rel_part;
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid)
    begin
      r_next.aw_have = 1'b0;
      r_next.w_have  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = mapped(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (r_reg.awaddr)
        OFS_CTRL:
          r_next.ctrl = ctrl_t'(11'(wmerge({21'h00_0000, r_reg.ctrl}, r_reg.wdata,
                                           r_reg.wstrb)));
        OFS_SEL:
          r_next.sel = 6'(wmerge({26'h000_0000, r_reg.sel}, r_reg.wdata, r_reg.wstrb));
        OFS_RELEASE:
        begin
          wv = wmerge({18'h0_0000, r_reg.rel_cs}, r_reg.wdata, r_reg.wstrb);
          if (wv < {18'h0_0000, RELEASE_CS_MIN})
            r_next.rel_cs = RELEASE_CS_MIN;
          else if (wv > {18'h0_0000, RELEASE_CS_MAX})
            r_next.rel_cs = RELEASE_CS_MAX;
          else
            r_next.rel_cs = wv[13:0];
        end
        OFS_CAL:
        begin
          wv = wmerge({r_reg.span, r_reg.offset}, r_reg.wdata, r_reg.wstrb);
          r_next.offset = wv[15:0];
          r_next.span   = wv[31:16];
        end
        OFS_RAMP:
          r_next.ramp = 12'(wmerge({20'h0_0000, r_reg.ramp}, r_reg.wdata, r_reg.wstrb));
        OFS_CMD:
          r_next.cmd = 16'(wmerge({16'h0000, r_reg.cmd}, r_reg.wdata, r_reg.wstrb));
        OFS_SCROLL:
          if (r_reg.mode == MODE_MASTER || r_reg.mode == MODE_RATIO)
          begin
            r_next.inj     = 1'b1;
            r_next.inj_err = wmerge(32'h0000_0000, r_reg.wdata, r_reg.wstrb);
          end
        OFS_PHASE:
          // A part released in the same cycle survives the clear
          r_next.phase_err = rel_valid ? rel_part : 32'h0000_0000;
        default:
          if (sp_hit(r_reg.awaddr))
            r_next.sp[sp_pos(r_reg.awaddr)] =
              16'(wmerge({16'h0000, r_reg.sp[sp_pos(r_reg.awaddr)]}, r_reg.wdata,
                         r_reg.wstrb));
      endcase
    end
    if (r_reg.bvalid && i_axi.bready)
    begin
      r_next.bvalid  = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready  = 1'b1;
    end

    // Register reads
    if (i_axi.arvalid && r_reg.arready)
    begin
      r_next.arready = 1'b0;
      r_next.rvalid  = 1'b1;
      r_next.rresp   = mapped(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
      case (i_axi.araddr)
        OFS_CTRL:    r_next.rdata = {21'h00_0000, r_reg.ctrl};
        OFS_SEL:     r_next.rdata = {26'h000_0000, r_reg.sel};
        OFS_RELEASE: r_next.rdata = {18'h0_0000, r_reg.rel_cs};
        OFS_CAL:     r_next.rdata = {r_reg.span, r_reg.offset};
        OFS_RAMP:    r_next.rdata = {20'h0_0000, r_reg.ramp};
        OFS_CMD:     r_next.rdata = {16'h0000, r_reg.cmd};
        OFS_STATUS:  r_next.rdata = {3'b000, r_reg.code, 6'h00, rel_busy, r_reg.dec,
                                     r_reg.drive_neg, r_reg.contactor_rev, r_reg.sp_idx,
                                     r_reg.mode};
        OFS_PHASE:   r_next.rdata = r_reg.phase_err;
        OFS_REF:     r_next.rdata = r_reg.ref_v;
        default:
          if (sp_hit(i_axi.araddr))
            r_next.rdata = {16'h0000, r_reg.sp[sp_pos(i_axi.araddr)]};
          else
            r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (r_reg.rvalid && i_axi.rready)
    begin
      r_next.rvalid  = 1'b0;
      r_next.arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r_reg         <= '0;
      r_reg.awready <= 1'b1;
      r_reg.wready  <= 1'b1;
      r_reg.arready <= 1'b1;
      r_reg.ctrl    <= ctrl_t'(CTRL_RST);
      r_reg.sel     <= SEL_RST;
      r_reg.rel_cs  <= RELEASE_CS_RST;
      r_reg.offset  <= OFFSET_RST;
      r_reg.span    <= SPAN_RST;
      r_reg.ramp    <= RAMP_RST;
    end
    else
      r_reg <= r_next;
  end

  assign o_axi.awready   = r_reg.awready;
  assign o_axi.wready    = r_reg.wready;
  assign o_axi.bvalid    = r_reg.bvalid;
  assign o_axi.bresp     = r_reg.bresp;
  assign o_axi.arready   = r_reg.arready;
  assign o_axi.rvalid    = r_reg.rvalid;
  assign o_axi.rdata     = r_reg.rdata;
  assign o_axi.rresp     = r_reg.rresp;
  assign o_drive_mag     = r_reg.drive_mag;
  assign o_drive_neg     = r_reg.drive_neg;
  assign o_contactor_rev = r_reg.contactor_rev;
  assign o_ref_value     = r_reg.ref_v;
  assign o_fb_enc_pulse  = r_reg.enc_out;
  assign o_fb_idx_pulse  = r_reg.idx_out;
  assign o_loop_tick     = r_reg.tick;
  assign o_mode          = r_reg.mode;
  assign o_setpoint      = r_reg.sp_val;
  assign o_phase_err     = r_reg.phase_err;
endmodule // motor_output_mode_control

// [dv/motor_output_mode_control_assertions.sv]
`timescale 1ns/1ns
module motor_output_mode_control_assertions #(
  parameter int unsigned CLK_HZ = 32'h0000_1000
) (
  input wire logic                i_clk,
  input wire logic                i_nrst,
  input wire motor_pkg::axi_req_t i_axi,
  input wire motor_pkg::axi_rsp_t o_axi,
  input wire motor_pkg::sw_t      i_sw,
  input wire logic [11:0]         o_drive_mag,
  input wire logic                o_drive_neg,
  input wire logic                o_contactor_rev,
  input wire logic [31:0]         o_ref_value,
  input wire logic                o_fb_enc_pulse,
  input wire logic                o_fb_idx_pulse,
  input wire logic                o_loop_tick,
  input wire motor_pkg::mode_t    o_mode
);
  import motor_pkg::*;
  localparam int GAP = CLK_HZ / LOOP_HZ;
  logic [15:0] gap_reg;
  logic        seen_reg;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // Cycles since the previous loop tick
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      gap_reg  <= '0;
      seen_reg <= 1'b0;
    end
    else
    begin
      gap_reg  <= o_loop_tick ? 16'h0001 : gap_reg + 16'h0001;
      seen_reg <= seen_reg | o_loop_tick;
    end
  AST_TICK_GAP:
    assert property (o_loop_tick && seen_reg |-> gap_reg == 16'(GAP))
    else $error("loop tick spacing wrong");
  AST_REF_ON_TICK:
    assert property ($changed(o_ref_value) |->
      o_loop_tick || $past(o_loop_tick) || $past(o_loop_tick, 2))
    else $error("reference moved off a loop tick");
  AST_DRIVE_ON_TICK:
    assert property ($changed(o_drive_mag) |->
      o_loop_tick || $past(o_loop_tick) || $past(o_loop_tick, 2))
    else $error("drive code moved off a loop tick");
  AST_CONTACTOR_POS:
    assert property (o_contactor_rev |-> !o_drive_neg)
    else $error("negative code with contactor reverse");
  AST_ENC_GATE:
    assert property (o_fb_enc_pulse |-> $past(i_sw.fb_enc, 3))
    else $error("encoder pulse without input");
  AST_IDX_GATE:
    assert property (o_fb_idx_pulse |-> $past(i_sw.fb_idx, 3))
    else $error("index pulse without input");
  AST_JOG_SW:
    assert property (o_mode == MODE_JOG |->
      $past(i_sw.jog, 3) || $past(i_sw.jog, 4) || $past(i_sw.jog, 5))
    else $error("jog mode without jog switch");
  AST_R_AFTER_AR:
    assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
    else $error("read data late");
  AST_AR_BLOCK:
    assert property (o_axi.rvalid |-> !o_axi.arready)
    else $error("read accepted while answer pending");
endmodule // motor_output_mode_control_assertions

// [dv/motor_drive_model.sv]
`timescale 1ns/1ns
module motor_drive_model (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_drive_mag,
  output logic             o_enc,
  output logic             o_idx
);
  logic [4:0] pos_reg = '0;
  // Shaft turns only while the drive code is nonzero
  always_ff @(posedge i_clk)
    if (i_drive_mag != 12'h000)
      pos_reg <= pos_reg + 5'h01;
  assign o_enc = pos_reg[1];
  assign o_idx = (pos_reg[4:1] == 4'h0);
endmodule // motor_drive_model

// [dv/motor_output_mode_control_tb_top.sv]
`timescale 1ns/1ns
module motor_output_mode_control_tb_top;
  import motor_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  axi_req_t    i_axi = '0;
  axi_rsp_t    o_axi;
  sw_t         i_sw;
  logic        jog = 1'b0, ol = 1'b0, mf = 1'b0, enc, idx;
  logic [1:0]  sp = 2'h1;
  logic        i_idx_meas_valid = 1'b0;
  logic [31:0] i_idx_meas_err = '0;
  logic [11:0] o_drive_mag;
  logic        o_drive_neg, o_contactor_rev, o_fb_enc_pulse, o_fb_idx_pulse, o_loop_tick;
  logic [31:0] o_ref_value, o_phase_err, q;
  logic [15:0] o_setpoint;
  mode_t       o_mode;
  int          failures = 0, n_compared = 0, n_enc = 0, n_idx = 0, e0, x0, t;
  logic [31:0] rst_v [5] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0064,
                             32'h2710_0000, 32'h0000_0001};
  logic [11:0] mode_c [5] = '{12'h000, 12'h002, 12'h001, 12'h081, 12'h080};
  mode_t       mode_e [5] = '{MODE_RATIO, MODE_INDEX, MODE_MASTER, MODE_RATIO, MODE_MASTER};
  logic [11:0] sp_c [3] = '{12'h001, 12'h000, 12'h102};
  logic [5:0]  sp_s [3] = '{6'h02, 6'h0c, 6'h30};
  logic [15:0] sp_e [3] = '{16'h0102, 16'h0107, 16'h0109};
  assign i_sw = {jog, ol, mf, sp, enc, idx};
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    n_enc <= n_enc + o_fb_enc_pulse;
    n_idx <= n_idx + o_fb_idx_pulse;
  end
  motor_output_mode_control #(.CLK_HZ(32'h0000_1000)) u_motor_output_mode_control (
    .i_clk, .i_nrst, .i_axi, .o_axi, .i_sw, .i_idx_meas_valid, .i_idx_meas_err,
    .o_drive_mag, .o_drive_neg, .o_contactor_rev, .o_ref_value, .o_fb_enc_pulse,
    .o_fb_idx_pulse, .o_loop_tick, .o_mode, .o_setpoint, .o_phase_err);
  motor_drive_model u_motor_drive_model (
    .i_clk, .i_drive_mag(o_drive_mag), .o_enc(enc), .o_idx(idx));
  task automatic report_and_stop;
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    @(posedge i_clk);
    i_axi <= '{awvalid: w, awaddr: a, wvalid: w, wdata: d, wstrb: 4'hf,
               bready: w, arvalid: !w, araddr: a, rready: !w};
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
      if (o_axi.awready)
        i_axi.awvalid <= 1'b0;
      if (o_axi.wready)
        i_axi.wvalid <= 1'b0;
      if (o_axi.arready)
        i_axi.arvalid <= 1'b0;
    end
    while (!(w ? o_axi.bvalid : o_axi.rvalid) && n < 200);
    q = o_axi.rdata;
    i_axi.bready <= 1'b0;
    i_axi.rready <= 1'b0;
    chk("resp", w ? o_axi.bresp : o_axi.rresp, er);
    if (n >= 200)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, RESP_OKAY);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, '0, RESP_OKAY);
    chk("rdata", q, e);
  endtask
  // Waits for n loop ticks
  task automatic wt(input int n);
    int k;
    k = 0;
    repeat (n)
      do
      begin
        @(posedge i_clk);
        k++;
      end
      while (!o_loop_tick && k < 40 * n);
    if (k >= 40 * n)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 5; i++)
      rc(8'(4 * i), rst_v[i]);
    acc(1'b0, 8'h28, '0, RESP_SLVERR);
    chk("unmapped", q, '0);
    acc(1'b1, 8'h30, 32'h0000_0001, RESP_SLVERR);
    wr(OFS_CAL, 32'h2710_0010);
    wr(OFS_CMD, 32'h0000_ec78);
    wt(4);
    chk("mag", o_drive_mag, 32'h0000_0fff);
    chk("neg", o_drive_neg, 1'b1);
    chk("ref", o_ref_value, 32'hffff_d900);
    wr(OFS_CMD, 32'h0000_0064);
    wt(4);
    chk("neg", o_drive_neg, 1'b0);
    chk("ref", o_ref_value, 32'h0000_0104);
    wr(OFS_CTRL, 32'h0000_0041);
    wr(OFS_CMD, 32'h0000_ff9c);
    wt(4);
    chk("rev", o_contactor_rev, 1'b1);
    chk("neg", o_drive_neg, 1'b0);
    chk("ref", o_ref_value, 32'h0000_0104);
    wr(OFS_CMD, 32'h0000_0064);
    wt(4);
    chk("rev", o_contactor_rev, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      mf <= (i == 4);
      wr(OFS_CTRL, 32'(mode_c[i]));
      wt(2);
      chk("mode", o_mode, mode_e[i]);
    end
    for (int i = 0; i < 13; i++)
      wr(8'(OFS_SP_BASE + 4 * i), 32'(16'h0100 + i));
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL, 32'(sp_c[i]));
      wr(OFS_SEL, 32'(sp_s[i]));
      wt(2);
      chk("setpoint", o_setpoint, 32'(sp_e[i]));
    end
    wr(OFS_CTRL, 32'h0000_020d);
    wr(OFS_RAMP, 32'h0000_0004);
    wr(OFS_SP_LAST, 32'h0000_0028);
    wr(OFS_CMD, '0);
    wt(4);
    jog <= 1'b1;
    wt(3);
    chk("mode", o_mode, MODE_JOG);
    chk("accel", o_drive_mag > 0 && o_drive_mag < 40, 1'b1);
    wt(14);
    chk("mag", o_drive_mag, 32'h0000_0028);
    jog <= 1'b0;
    wt(3);
    chk("decel", o_drive_mag > 0 && o_drive_mag < 40, 1'b1);
    wt(14);
    chk("mag", o_drive_mag, '0);
    // Acceleration ramp only: leaving jog drops straight to the loop demand
    wr(OFS_CTRL, 32'h0000_0205);
    jog <= 1'b1;
    wt(17);
    chk("mag", o_drive_mag, 32'h0000_0028);
    jog <= 1'b0;
    wt(3);
    chk("mag", o_drive_mag, '0);
    wr(OFS_CMD, 32'h0000_0064);
    ol <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_CTRL, 32'h0000_0401 | 32'(c << 4));
      wt(2);
      e0 = n_enc;
      x0 = n_idx;
      wt(16);
      chk("enc", n_enc == e0, c[0]);
      chk("idx", n_idx == x0, c[1]);
    end
    ol <= 1'b0;
    wr(OFS_RELEASE, '0);
    rc(OFS_RELEASE, 32'h0000_0001);
    wr(OFS_RELEASE, 32'h0000_4e20);
    rc(OFS_RELEASE, 32'h0000_2710);
    wr(OFS_RELEASE, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_PHASE, '0);
    wr(OFS_SCROLL, 32'h0000_03eb);
    t = 0;
    while (o_phase_err === '0 && t < 100)
    begin
      @(posedge i_clk);
      t++;
    end
    chk("part", o_phase_err, 32'h0000_0064);
    wt(12);
    chk("phase", o_phase_err, 32'h0000_03eb);
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_SCROLL, 32'h0000_0032);
    i_idx_meas_valid <= 1'b1;
    i_idx_meas_err <= 32'h0000_0007;
    @(posedge i_clk);
    i_idx_meas_valid <= 1'b0;
    wt(12);
    chk("phase", o_phase_err, 32'h0000_03f2);
    report_and_stop();
  end
endmodule // motor_output_mode_control_tb_top
bind motor_output_mode_control motor_output_mode_control_assertions #(.CLK_HZ(CLK_HZ)) u_chk (
  .i_clk, .i_nrst, .i_axi, .o_axi, .i_sw, .o_drive_mag, .o_drive_neg, .o_contactor_rev,
  .o_ref_value, .o_fb_enc_pulse, .o_fb_idx_pulse, .o_loop_tick, .o_mode);
